//--- rtl/sdb_defs.svh
`ifndef SDB_DEFS_SVH
`define SDB_DEFS_SVH
// request byte
`define SDB_REQ_RESET_BIT     7
// response byte
`define SDB_RSP_OUT_ON_BIT    0
`define SDB_RSP_ACT_DET_BIT   1
`define SDB_RSP_INPUTS_BIT    4
`define SDB_RSP_LIMIT_BIT     5
`define SDB_RSP_WARN_BIT      6
`define SDB_RSP_ERR_BIT       7
// warning / error detail byte
`define SDB_DIAG_OUT1_BIT     0
`define SDB_DIAG_OUT2_BIT     1
`define SDB_DIAG_CROSS_BIT    2
`define SDB_DIAG_TEMP_BIT     3
`define SDB_DIAG_ACT_BAD_BIT  4
`define SDB_DIAG_INTERNAL_BIT 5
`define SDB_DIAG_COMM_BIT     6
`define SDB_BYTE_RESET        8'h00
`endif

//--- rtl/sdb_pkg.sv
package sdb_pkg;
  typedef logic [7:0] sdb_byte_t;
  typedef enum logic [1:0] {
    SDB_ERR_IDLE  = 2'b01,
    SDB_ERR_LATCH = 2'b10
  } sdb_err_state_t;
endpackage : sdb_pkg

//--- rtl/sdb_err_if.sv
`timescale 1ns/1ps
`default_nettype none
interface sdb_err_if;
  logic cause;
  logic clear_req;
  logic latched;
  modport owner (input cause, input clear_req, output latched);
  modport user  (output cause, output clear_req, input latched);
endinterface : sdb_err_if
`default_nettype wire

//--- rtl/sdb_err_latch.sv
`timescale 1ns/1ps
`default_nettype none
module sdb_err_latch (
  input  wire logic     clk_i,
  input  wire logic     resetn_i,
  sdb_err_if.owner      err
);
  sdb_pkg::sdb_err_state_t state;
  sdb_pkg::sdb_err_state_t next_state;

  // a clear is only honoured once the cause is gone
  always_comb begin
    next_state = state;
    case (state)
      sdb_pkg::SDB_ERR_IDLE: begin
        if (err.cause) next_state = sdb_pkg::SDB_ERR_LATCH;
      end
      sdb_pkg::SDB_ERR_LATCH: begin
        if (!err.cause && err.clear_req) next_state = sdb_pkg::SDB_ERR_IDLE;
      end
      default: next_state = sdb_pkg::SDB_ERR_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) state <= sdb_pkg::SDB_ERR_IDLE;
    else state <= next_state;
  end

  assign err.latched = (state == sdb_pkg::SDB_ERR_LATCH);

  property p_err_hold;
    @(posedge clk_i) disable iff (!resetn_i)
      (state == sdb_pkg::SDB_ERR_LATCH) && err.cause
        |=> state == sdb_pkg::SDB_ERR_LATCH;
  endproperty
  a_err_hold: assert property (p_err_hold)
    else $error("error cleared while cause present");
endmodule : sdb_err_latch
`default_nettype wire

//--- rtl/sdb_status.sv
`include "sdb_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module sdb_status (
  input  wire logic               clk_i,
  input  wire logic               resetn_i,
  input  wire sdb_pkg::sdb_byte_t request_i,
  input  wire logic               guard_open_i,
  input  wire logic               safety_output_one_i,
  input  wire logic               safety_output_two_i,
  input  wire logic               safety_input_one_i,
  input  wire logic               safety_input_two_i,
  input  wire logic               actuator_in_range_i,
  input  wire logic               actuator_in_hyst_i,
  input  wire logic               actuator_bad_i,
  input  wire logic               fault_out_one_i,
  input  wire logic               fault_out_two_i,
  input  wire logic               fault_cross_i,
  input  wire logic               fault_temp_i,
  input  wire logic               fault_internal_i,
  input  wire logic               fault_comm_i,
  input  wire logic               warn_cause_i,
  input  wire logic               err_cause_i,
  output var  sdb_pkg::sdb_byte_t response_o,
  output var  sdb_pkg::sdb_byte_t diag_o,
  output var  logic               error_latched_o
);
  logic               req_reset_q;
  logic               req_fall;
  logic               clear_req;
  sdb_pkg::sdb_byte_t next_response;
  sdb_pkg::sdb_byte_t next_diag;
  sdb_err_if          err ();

  assign req_fall  = req_reset_q && !request_i[`SDB_REQ_RESET_BIT];
  assign clear_req = req_fall || guard_open_i;
  assign err.cause     = err_cause_i;
  assign err.clear_req = clear_req;

  sdb_err_latch u_err (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .err      (err)
  );

  // each bit from its own condition, so mixed states combine freely
  always_comb begin
    next_response = `SDB_BYTE_RESET;
    next_response[`SDB_RSP_OUT_ON_BIT] =
      safety_output_one_i && safety_output_two_i;
    next_response[`SDB_RSP_ACT_DET_BIT] = actuator_in_range_i;
    next_response[`SDB_RSP_INPUTS_BIT] =
      safety_input_one_i && safety_input_two_i;
    next_response[`SDB_RSP_LIMIT_BIT] = actuator_in_hyst_i;
    next_response[`SDB_RSP_WARN_BIT]  = warn_cause_i;
    next_response[`SDB_RSP_ERR_BIT]   = err.latched;
  end

  always_comb begin
    next_diag = `SDB_BYTE_RESET;
    next_diag[`SDB_DIAG_OUT1_BIT]     = fault_out_one_i;
    next_diag[`SDB_DIAG_OUT2_BIT]     = fault_out_two_i;
    next_diag[`SDB_DIAG_CROSS_BIT]    = fault_cross_i;
    next_diag[`SDB_DIAG_TEMP_BIT]     = fault_temp_i;
    next_diag[`SDB_DIAG_ACT_BAD_BIT]  = actuator_bad_i;
    next_diag[`SDB_DIAG_INTERNAL_BIT] = fault_internal_i;
    next_diag[`SDB_DIAG_COMM_BIT]     = fault_comm_i;
  end

  // registered so the line sees glitch-free bytes
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      req_reset_q     <= 1'b0;
      response_o      <= `SDB_BYTE_RESET;
      diag_o          <= `SDB_BYTE_RESET;
      error_latched_o <= 1'b0;
    end else begin
      req_reset_q     <= request_i[`SDB_REQ_RESET_BIT];
      response_o      <= next_response;
      diag_o          <= next_diag;
      error_latched_o <= err.latched;
    end
  end

  property p_inputs;
    @(posedge clk_i) disable iff (!resetn_i)
      ##1 response_o[`SDB_RSP_INPUTS_BIT] ==
      ($past(safety_input_one_i) && $past(safety_input_two_i));
  endproperty
  a_inputs: assert property (p_inputs)
    else $error("input bit wrong");

  property p_hyst;
    @(posedge clk_i) disable iff (!resetn_i)
      actuator_in_hyst_i |=> response_o[`SDB_RSP_LIMIT_BIT];
  endproperty
  a_hyst: assert property (p_hyst)
    else $error("limit bit missing");

  property p_comm;
    @(posedge clk_i) disable iff (!resetn_i)
      fault_comm_i |=> diag_o[`SDB_DIAG_COMM_BIT];
  endproperty
  a_comm: assert property (p_comm)
    else $error("comm bit missing");

  property p_act_bad;
    @(posedge clk_i) disable iff (!resetn_i)
      actuator_bad_i |=> diag_o[`SDB_DIAG_ACT_BAD_BIT];
  endproperty
  a_act_bad: assert property (p_act_bad)
    else $error("actuator bit missing");

  property p_out_on;
    @(posedge clk_i) disable iff (!resetn_i)
      !(safety_output_one_i && safety_output_two_i)
        |=> !response_o[`SDB_RSP_OUT_ON_BIT];
  endproperty
  a_out_on: assert property (p_out_on)
    else $error("output bit set wrongly");

  property p_warn;
    @(posedge clk_i) disable iff (!resetn_i)
      warn_cause_i |=> response_o[`SDB_RSP_WARN_BIT];
  endproperty
  a_warn: assert property (p_warn)
    else $error("warning bit missing");

  property p_err_set;
    @(posedge clk_i) disable iff (!resetn_i)
      err_cause_i |=> ##1 response_o[`SDB_RSP_ERR_BIT];
  endproperty
  a_err_set: assert property (p_err_set)
    else $error("error bit missing");

  property p_err_stay;
    @(posedge clk_i) disable iff (!resetn_i)
      err.latched && !clear_req |=> ##1 error_latched_o;
  endproperty
  a_err_stay: assert property (p_err_stay)
    else $error("error cleared without request");

  property p_range;
    @(posedge clk_i) disable iff (!resetn_i)
      actuator_in_range_i |=> response_o[`SDB_RSP_ACT_DET_BIT];
  endproperty
  a_range: assert property (p_range)
    else $error("actuator bit missing");

  property p_temp;
    @(posedge clk_i) disable iff (!resetn_i)
      fault_temp_i |=> diag_o[`SDB_DIAG_TEMP_BIT];
  endproperty
  a_temp: assert property (p_temp)
    else $error("temperature bit missing");

  property p_out1;
    @(posedge clk_i) disable iff (!resetn_i)
      fault_out_one_i |=> diag_o[`SDB_DIAG_OUT1_BIT];
  endproperty
  a_out1: assert property (p_out1)
    else $error("output one fault bit missing");

  property p_out2;
    @(posedge clk_i) disable iff (!resetn_i)
      fault_out_two_i |=> diag_o[`SDB_DIAG_OUT2_BIT];
  endproperty
  a_out2: assert property (p_out2)
    else $error("output two fault bit missing");

  property p_cross;
    @(posedge clk_i) disable iff (!resetn_i)
      fault_cross_i |=> diag_o[`SDB_DIAG_CROSS_BIT];
  endproperty
  a_cross: assert property (p_cross)
    else $error("cross fault bit missing");

  property p_internal;
    @(posedge clk_i) disable iff (!resetn_i)
      fault_internal_i |=> diag_o[`SDB_DIAG_INTERNAL_BIT];
  endproperty
  a_internal: assert property (p_internal)
    else $error("internal fault bit missing");

  // undefined positions must stay low whatever the inputs do
  property p_spare;
    @(posedge clk_i) disable iff (!resetn_i)
      ##1 ((response_o[3:2] == 2'b00) && !diag_o[7]);
  endproperty
  a_spare: assert property (p_spare)
    else $error("spare bit set");

  property p_err_clear;
    @(posedge clk_i) disable iff (!resetn_i)
      err.latched && !err_cause_i && clear_req
        |=> ##1 !response_o[`SDB_RSP_ERR_BIT];
  endproperty
  a_err_clear: assert property (p_err_clear)
    else $error("error not cleared");

  property p_warn_off;
    @(posedge clk_i) disable iff (!resetn_i)
      !warn_cause_i |=> !response_o[`SDB_RSP_WARN_BIT];
  endproperty
  a_warn_off: assert property (p_warn_off)
    else $error("warning bit set wrongly");

  property p_range_off;
    @(posedge clk_i) disable iff (!resetn_i)
      !actuator_in_range_i |=> !response_o[`SDB_RSP_ACT_DET_BIT];
  endproperty
  a_range_off: assert property (p_range_off)
    else $error("actuator bit set wrongly");
endmodule : sdb_status
`default_nettype wire

//--- tb/sdb_gw_model.sv
`timescale 1ns/1ps
`default_nettype none
module sdb_gw_model (
  input  wire logic               clk_i,
  input  wire logic               resetn_i,
  input  wire logic               clear_i,
  output var  sdb_pkg::sdb_byte_t request_o
);
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      request_o <= 8'h00;
    end else begin
      // spare bits churn every cycle so a decoder leaning on them shows
      request_o[6:0] <= request_o[6:0] + 7'h35;
      // one-cycle high then low: the falling edge is the reset request
      request_o[7]   <= clear_i;
    end
  end
endmodule : sdb_gw_model
`default_nettype wire

//--- tb/serial_diag_status_bytes_tb.sv
`timescale 1ns/1ps
`default_nettype none
module serial_diag_status_bytes_tb;
  logic               clk_i;
  logic               resetn_i;
  logic               clear;
  logic               errx;
  logic               latched;
  logic [15:0]        c;
  int                 mismatches;
  int                 checked;
  sdb_pkg::sdb_byte_t request;
  sdb_pkg::sdb_byte_t response;
  sdb_pkg::sdb_byte_t diag;
  logic [15:0]        pats [5] = '{16'h0003, 16'h000C, 16'h3FFF,
                                   16'h2AAA, 16'h1555};
  sdb_gw_model sdb_gw_model_inst (.clk_i(clk_i), .resetn_i(resetn_i),
    .clear_i(clear), .request_o(request));
  sdb_status sdb_status_inst (.clk_i(clk_i), .resetn_i(resetn_i),
    .request_i(request), .guard_open_i(c[15]),
    .safety_output_one_i(c[0]), .safety_output_two_i(c[1]),
    .safety_input_one_i(c[2]), .safety_input_two_i(c[3]),
    .actuator_in_range_i(c[4]), .actuator_in_hyst_i(c[5]),
    .actuator_bad_i(c[6]), .fault_out_one_i(c[7]),
    .fault_out_two_i(c[8]), .fault_cross_i(c[9]), .fault_temp_i(c[10]),
    .fault_internal_i(c[11]), .fault_comm_i(c[12]),
    .warn_cause_i(c[13]), .err_cause_i(c[14]), .response_o(response),
    .diag_o(diag), .error_latched_o(latched));
  task automatic conclude();
    if (mismatches == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : conclude
  task automatic cmp(input sdb_pkg::sdb_byte_t got, exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  task automatic settle(input int n);
    repeat (n) @(posedge clk_i);
    @(negedge clk_i);
  endtask : settle
  task automatic apply(input logic [15:0] v);
    sdb_pkg::sdb_byte_t er;
    sdb_pkg::sdb_byte_t ed;
    er = {errx, v[13], v[5], v[2] & v[3], 2'h0, v[4], v[0] & v[1]};
    ed = {1'h0, v[12], v[11], v[6], v[10], v[9], v[8], v[7]};
    @(posedge clk_i);
    c <= v;
    settle(1);
    cmp(response, er);
    cmp(diag, ed);
  endtask : apply
  task automatic pulse_clear();
    @(posedge clk_i);
    clear <= 1'h1;
    @(posedge clk_i);
    clear <= 1'h0;
    settle(6);
  endtask : pulse_clear
  initial begin
    clk_i = 1'h0;
    forever #4 clk_i = ~clk_i;
  end
  initial begin
    repeat (3000) @(posedge clk_i);
    mismatches++;
    conclude();
  end
  initial begin
    resetn_i = 1'h0;
    clear = 1'h0;
    errx = 1'h0;
    c = 16'h0000;
    mismatches = 0;
    checked = 0;
    repeat (10) @(posedge clk_i);
    resetn_i <= 1'h1;
    for (int i = 0; i < 14; i++) apply(16'h0001 << i);
    foreach (pats[i]) apply(pats[i]);
    @(posedge clk_i);
    c <= 16'h4000;
    settle(1);
    cmp(response, 8'h00);
    settle(0);
    @(posedge clk_i);
    @(negedge clk_i);
    cmp(response, 8'h80);
    errx = 1'h1;
    apply(16'h4003);
    // cause still present, so the reset request must be refused
    pulse_clear();
    cmp({7'h00, latched}, 8'h01);
    apply(16'h0000);
    pulse_clear();
    cmp({7'h00, latched}, 8'h00);
    cmp(response, 8'h00);
    errx = 1'h0;
    @(posedge clk_i);
    c <= 16'h4000;
    settle(2);
    cmp({7'h00, latched}, 8'h01);
    @(posedge clk_i);
    c <= 16'h8000;
    @(posedge clk_i);
    c <= 16'h0000;
    settle(3);
    cmp({7'h00, latched}, 8'h00);
    conclude();
  end
endmodule : serial_diag_status_bytes_tb
`default_nettype wire
